// File: ensr_pkg.sv
// ****************************************************************
// Shared constants of the sensor result and status registers.
// ****************************************************************
package ensr_pkg;

   // Register pointer values of the registers held in this block.
   localparam logic [7:0] ADDR_TEMP_LOW = 8'h00;
   localparam logic [7:0] ADDR_TEMP_HIGH = 8'h01;
   localparam logic [7:0] ADDR_HUMID_LOW = 8'h02;
   localparam logic [7:0] ADDR_HUMID_HIGH = 8'h03;
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_TEMP_PEAK = 8'h05;
   localparam logic [7:0] ADDR_HUMID_PEAK = 8'h06;
   localparam logic [7:0] ADDR_EVENT_ENABLES = 8'h07;
   // First pointer value past the map of this block.
   localparam logic [7:0] ADDR_LIMIT = 8'h08;
   localparam logic [7:0] PTR_STEP = 8'h01;

   // Widths of the conversion code and the result registers.
   localparam int CODE_W = 14;
   localparam int RESULT_W = 16;
   localparam int FLAG_W = 5;
   localparam logic [1:0] RESULT_PAD = 2'h0;

   // Flag and enable positions inside the five-bit event field.
   localparam int EV_READY = 4;
   localparam int EV_TEMP_HIGH = 3;
   localparam int EV_TEMP_LOW = 2;
   localparam int EV_HUMID_HIGH = 1;
   localparam int EV_HUMID_LOW = 0;
   // Reserved low bits of the event registers, read as zero.
   localparam logic [2:0] RESERVED_BITS = 3'h0;

   // Reset values.
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Resolution select codes and the code bits each one keeps.
   localparam logic [1:0] RES_14_BIT = 2'h0;
   localparam logic [1:0] RES_11_BIT = 2'h1;
   localparam logic [1:0] RES_9_BIT = 2'h2;
   localparam logic [13:0] MASK_14_BIT = 14'h3FFF;
   localparam logic [13:0] MASK_11_BIT = 14'h3FF8;
   localparam logic [13:0] MASK_9_BIT = 14'h3FE0;

   // Threshold flag behaviour selected by the interrupt mode bit.
   localparam logic MODE_STICKY = 1'b0;
   localparam logic MODE_COMPARE = 1'b1;

endpackage

// File: ensr_result_chan.sv
`timescale 1ns/1ps
// ****************************************************************
// One measurement channel: result, read shadow, peak and limits.
// ****************************************************************
module ensr_result_chan (
   // Clock, reset and enable.
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   // New conversion.
   input wire logic done_in,
   input wire logic [13:0] code_in,
   input wire logic [1:0] res_sel_in,
   // Limits and peak control.
   input wire logic [7:0] thr_low_in,
   input wire logic [7:0] thr_high_in,
   input wire logic peak_track_in,
   // Register accesses.
   input wire logic low_rd_in,
   input wire logic peak_wr_in,
   input wire logic [7:0] wr_data_in,
   // Register contents and limit hits of the new conversion.
   output logic [7:0] result_low_out,
   output logic [7:0] shadow_high_out,
   output logic [7:0] peak_out,
   output logic high_hit_out,
   output logic low_hit_out
);

   logic [15:0] result_reg;
   logic [7:0] shadow_reg;
   logic [7:0] peak_reg;
   logic [13:0] res_mask;
   logic [15:0] new_result;
   logic [7:0] new_upper;
   logic peak_rise;

   // Resolution trims the low code bits, two zero bits pad the bottom.
   assign res_mask = (res_sel_in == ensr_pkg::RES_11_BIT) ?
                     ensr_pkg::MASK_11_BIT :
                     (res_sel_in == ensr_pkg::RES_9_BIT) ?
                     ensr_pkg::MASK_9_BIT : ensr_pkg::MASK_14_BIT;
   assign new_result = {code_in & res_mask, ensr_pkg::RESULT_PAD};
   assign new_upper = new_result[15:8];
   assign peak_rise = done_in && peak_track_in && (new_upper > peak_reg);
   assign high_hit_out = new_upper > thr_high_in;
   assign low_hit_out = new_upper < thr_low_in;
   assign result_low_out = result_reg[7:0];
   assign shadow_high_out = shadow_reg;
   assign peak_out = peak_reg;

   // Result and the high byte frozen when the low byte is read.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         result_reg <= ensr_pkg::RESULT_RESET;
         shadow_reg <= ensr_pkg::BYTE_RESET;
      end else if (clk_en_in) begin
         if (low_rd_in) begin
            shadow_reg <= result_reg[15:8];
         end
         if (done_in) begin
            result_reg <= new_result;
         end
      end
   end

   // Peak hold keeps the highest upper byte seen while tracking, since the last reset or peak write.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         peak_reg <= ensr_pkg::BYTE_RESET;
      end else if (clk_en_in) begin
         if (peak_wr_in) begin
            peak_reg <= wr_data_in;
         end else if (peak_rise) begin
            peak_reg <= new_upper;
         end
      end
   end

endmodule // ensr_result_chan

// File: ensr_regs_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Temperature result is 16 bits, two zero LSBs.
// - Humidity result is 16 bits, two zero LSBs.
// - Conversion is 14 bits, trimmed by resolution.
// - Temperature code maps to Celsius linearly.
// - Humidity code maps to percent linearly.
// - Status flags at bits 7 to 3, rest zero.
// - Ready flag sets when any conversion completes.
// - Ready clears on status or result read.
// - Limit flags set on crossing, mode selects behaviour.
// - Status read clears every limit flag.
// - Event pin follows enabled flags, configured polarity.
// - Temperature peak holds maximum, cleared by resets.
// - Humidity peak holds maximum, cleared by resets.
// - Peak tracking stops in automatic measurement mode.
// - Temperature peak is the result upper byte.
// - Humidity peak is the result upper byte.
// - Enable register gates each flag onto the event pin.
// - Register pointer increments after each data byte.
// - Pointer to unused address is not acknowledged.
module ensr_regs_top (
   // Clock, reset and enable.
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   // Byte requests from the serial bus engine.
   input wire logic ptr_wr_in,
   input wire logic data_wr_in,
   input wire logic data_rd_in,
   input wire logic [7:0] byte_in,
   // Byte answers to the serial bus engine.
   output logic resp_valid_out,
   output logic ack_out,
   output logic [7:0] rd_data_out,
   // Conversion results.
   input wire logic temp_done_in,
   input wire logic [13:0] temp_code_in,
   input wire logic humid_done_in,
   input wire logic [13:0] humid_code_in,
   // Settings held by the neighbouring configuration registers.
   input wire logic [1:0] temp_res_in,
   input wire logic [1:0] humid_res_in,
   input wire logic [7:0] temp_thr_low_in,
   input wire logic [7:0] temp_thr_high_in,
   input wire logic [7:0] humid_thr_low_in,
   input wire logic [7:0] humid_thr_high_in,
   input wire logic soft_reset_in,
   input wire logic auto_meas_in,
   input wire logic pin_enable_in,
   input wire logic pin_polarity_in,
   input wire logic flag_mode_in,
   // Event pin.
   output logic event_out_pin
);

   // ****************************************************************
   // Registers and nets.
   // ****************************************************************
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;
   logic [4:0] flags_reg;
   logic [4:0] flags_next;
   logic [4:0] enables_reg;
   logic resp_valid_reg;
   logic ack_reg;
   logic ack_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic pin_reg;
   logic pin_next;
   logic blk_rst;
   logic ptr_used;
   logic ptr_writable;
   logic any_req;
   logic rd_hit;
   logic wr_hit;
   logic status_rd;
   logic result_rd;
   logic status_wr;
   logic [7:0] temp_low;
   logic [7:0] temp_high;
   logic [7:0] temp_peak;
   logic [7:0] humid_low;
   logic [7:0] humid_high;
   logic [7:0] humid_peak;
   logic temp_over;
   logic temp_under;
   logic humid_over;
   logic humid_under;
   logic [4:0] hits;
   logic [4:0] hit_valid;
   logic [4:0] kept;
   logic [4:0] wr_flags;
   logic event_active;

   // ****************************************************************
   // Request decode.
   // ****************************************************************

   // Soft reset acts like power-up reset on everything held here except the event pin register.
   assign blk_rst = srst_in | (clk_en_in & soft_reset_in);
   assign ptr_used = ptr_reg < ensr_pkg::ADDR_LIMIT;
   assign ptr_writable = ptr_used && (ptr_reg >= ensr_pkg::ADDR_EVENT_FLAGS);
   assign any_req = ptr_wr_in | data_wr_in | data_rd_in;
   assign rd_hit = data_rd_in && ptr_used;
   assign wr_hit = data_wr_in && ptr_writable;
   assign status_rd = rd_hit && (ptr_reg == ensr_pkg::ADDR_EVENT_FLAGS);
   assign result_rd = rd_hit && (ptr_reg < ensr_pkg::ADDR_EVENT_FLAGS);
   assign status_wr = wr_hit && (ptr_reg == ensr_pkg::ADDR_EVENT_FLAGS);

   // A pointer byte loads the pointer, data bytes step it on.
   assign ptr_next = ptr_wr_in ? byte_in :
                     (data_wr_in | data_rd_in) ?
                     ptr_reg + ensr_pkg::PTR_STEP : ptr_reg;

   // Unused pointer values and writes to result bytes are refused.
   assign ack_next = ptr_wr_in ? (byte_in < ensr_pkg::ADDR_LIMIT) :
                     data_wr_in ? ptr_writable : ptr_used;

   // ****************************************************************
   // Read data selection.
   // ****************************************************************

   // Selected register byte; unused pointer values read as zero.
   assign rd_data_next =
      (ptr_reg == ensr_pkg::ADDR_TEMP_LOW) ? temp_low :
      (ptr_reg == ensr_pkg::ADDR_TEMP_HIGH) ? temp_high :
      (ptr_reg == ensr_pkg::ADDR_HUMID_LOW) ? humid_low :
      (ptr_reg == ensr_pkg::ADDR_HUMID_HIGH) ? humid_high :
      (ptr_reg == ensr_pkg::ADDR_EVENT_FLAGS) ?
      {flags_reg, ensr_pkg::RESERVED_BITS} :
      (ptr_reg == ensr_pkg::ADDR_TEMP_PEAK) ? temp_peak :
      (ptr_reg == ensr_pkg::ADDR_HUMID_PEAK) ? humid_peak :
      (ptr_reg == ensr_pkg::ADDR_EVENT_ENABLES) ?
      {enables_reg, ensr_pkg::RESERVED_BITS} : ensr_pkg::BYTE_RESET;

   // ****************************************************************
   // Measurement channels.
   // ****************************************************************

   // Temperature channel.
   ensr_result_chan u_temp_chan (
      .sys_clk_in(sys_clk_in),
      .srst_in(blk_rst),
      .clk_en_in(clk_en_in),
      .done_in(temp_done_in),
      .code_in(temp_code_in),
      .res_sel_in(temp_res_in),
      .thr_low_in(temp_thr_low_in),
      .thr_high_in(temp_thr_high_in),
      .peak_track_in(~auto_meas_in),
      .low_rd_in(rd_hit && (ptr_reg == ensr_pkg::ADDR_TEMP_LOW)),
      .peak_wr_in(wr_hit && (ptr_reg == ensr_pkg::ADDR_TEMP_PEAK)),
      .wr_data_in(byte_in),
      .result_low_out(temp_low),
      .shadow_high_out(temp_high),
      .peak_out(temp_peak),
      .high_hit_out(temp_over),
      .low_hit_out(temp_under)
   );

   // Humidity channel.
   ensr_result_chan u_humid_chan (
      .sys_clk_in(sys_clk_in),
      .srst_in(blk_rst),
      .clk_en_in(clk_en_in),
      .done_in(humid_done_in),
      .code_in(humid_code_in),
      .res_sel_in(humid_res_in),
      .thr_low_in(humid_thr_low_in),
      .thr_high_in(humid_thr_high_in),
      .peak_track_in(~auto_meas_in),
      .low_rd_in(rd_hit && (ptr_reg == ensr_pkg::ADDR_HUMID_LOW)),
      .peak_wr_in(wr_hit && (ptr_reg == ensr_pkg::ADDR_HUMID_PEAK)),
      .wr_data_in(byte_in),
      .result_low_out(humid_low),
      .shadow_high_out(humid_high),
      .peak_out(humid_peak),
      .high_hit_out(humid_over),
      .low_hit_out(humid_under)
   );

   // ****************************************************************
   // Event flags and event pin.
   // ****************************************************************

   // Events raised by this cycle's conversions, in flag order.
   assign hits = {temp_done_in | humid_done_in,
                  temp_done_in & temp_over,
                  temp_done_in & temp_under,
                  humid_done_in & humid_over,
                  humid_done_in & humid_under};

   // Flags that a conversion this cycle re-evaluates in compare mode.
   assign hit_valid = {1'b0, temp_done_in, temp_done_in,
                       humid_done_in, humid_done_in};

   // Clearing by reads; compare mode also drops a flag no longer hit.
   assign kept[ensr_pkg::EV_READY] = flags_reg[ensr_pkg::EV_READY] &
                                     ~(status_rd | result_rd);
   assign kept[3:0] = flags_reg[3:0] & {4{~status_rd}} &
                      ~(hit_valid[3:0] &
                        {4{flag_mode_in == ensr_pkg::MODE_COMPARE}});

   // A host write may set or clear flags; a new event always wins.
   assign wr_flags = status_wr ? byte_in[7:3] : kept;
   assign flags_next = wr_flags | hits;

   // Pin shows any enabled flag at the chosen polarity.
   assign event_active = |(flags_next & enables_reg);
   assign pin_next = (pin_enable_in & event_active) ? pin_polarity_in :
                     ~pin_polarity_in;

   // ****************************************************************
   // State registers.
   // ****************************************************************

   // Pointer, flags and enables.
   always_ff @(posedge sys_clk_in) begin
      if (blk_rst) begin
         ptr_reg <= ensr_pkg::BYTE_RESET;
         flags_reg <= ensr_pkg::FLAGS_RESET;
         enables_reg <= ensr_pkg::FLAGS_RESET;
      end else if (clk_en_in) begin
         ptr_reg <= ptr_next;
         flags_reg <= flags_next;
         if (wr_hit && (ptr_reg == ensr_pkg::ADDR_EVENT_ENABLES)) begin
            enables_reg <= byte_in[7:3];
         end
      end
   end

   // Answers to the bus engine, one cycle after each request.
   always_ff @(posedge sys_clk_in) begin
      if (blk_rst) begin
         resp_valid_reg <= 1'b0;
         ack_reg <= 1'b0;
         rd_data_reg <= ensr_pkg::BYTE_RESET;
      end else if (clk_en_in) begin
         resp_valid_reg <= any_req;
         if (any_req) begin
            ack_reg <= ack_next;
         end
         if (data_rd_in) begin
            rd_data_reg <= rd_data_next;
         end
      end
   end

   // Event pin register; reset loads low, the inactive level only for an active-high pin.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pin_reg <= 1'b0;
      end else if (clk_en_in) begin
         pin_reg <= pin_next;
      end
   end

   assign resp_valid_out = resp_valid_reg;
   assign ack_out = ack_reg;
   assign rd_data_out = rd_data_reg;
   assign event_out_pin = pin_reg;

endmodule // ensr_regs_top

// File: ensr_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host model: pointer, write and read bytes, one at a time.
// ****************************************************************
module ensr_host_model (
   // Clock.
   input wire logic sys_clk_in,
   // Answers of the register block.
   input wire logic resp_valid_in,
   input wire logic ack_in,
   input wire logic [7:0] rd_data_in,
   // Byte requests.
   output logic ptr_wr_out,
   output logic data_wr_out,
   output logic data_rd_out,
   output logic [7:0] byte_out
);
   logic got_resp;
   logic got_ack;
   logic [7:0] got_data;
   // Strobes are idle from time zero.
   initial begin
      ptr_wr_out = 1'b0;
      data_wr_out = 1'b0;
      data_rd_out = 1'b0;
      byte_out = 8'h00;
   end
   // A request stands for one edge; its answer is taken a cycle later.
   task automatic xfer(input logic [1:0] kind, input logic [7:0] b);
      @(posedge sys_clk_in);
      ptr_wr_out <= (kind == 2'h0);
      data_wr_out <= (kind == 2'h1);
      data_rd_out <= (kind == 2'h2);
      byte_out <= b;
      @(posedge sys_clk_in);
      ptr_wr_out <= 1'b0;
      data_wr_out <= 1'b0;
      data_rd_out <= 1'b0;
      byte_out <= ~b; // A released byte never keeps its last value.
      #1;
      got_resp = resp_valid_in;
      got_ack = ack_in;
      got_data = rd_data_in;
   endtask
endmodule // ensr_host_model

// File: ensr_regs_top_monitor.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker of the result and status registers.
// ****************************************************************
module ensr_regs_top_monitor (
   // Clock, reset and byte requests.
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   input wire logic ptr_wr_in,
   input wire logic data_wr_in,
   input wire logic data_rd_in,
   input wire logic [7:0] byte_in,
   // Settings and conversions.
   input wire logic soft_reset_in,
   input wire logic pin_enable_in,
   input wire logic pin_polarity_in,
   input wire logic temp_done_in,
   input wire logic humid_done_in,
   // Answers and the event pin.
   input wire logic resp_valid_out,
   input wire logic ack_out,
   input wire logic [7:0] rd_data_out,
   input wire logic event_out_pin
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);
   // Request decode: taken requests, clean reads and writes, idle cycles.
   wire logic req = clk_en_in && !soft_reset_in &&
      (ptr_wr_in || data_wr_in || data_rd_in);
   wire logic ptr_go = req && ptr_wr_in;
   wire logic rd_go = req && data_rd_in && !ptr_wr_in && !data_wr_in;
   wire logic wr_go = req && data_wr_in && !ptr_wr_in && !data_rd_in;
   wire logic idle = !soft_reset_in &&
      !(ptr_wr_in || data_wr_in || data_rd_in);

   chk_answer_next: assert property (req |=> resp_valid_out)
      else $error("Byte request not answered next cycle.");
   chk_answer_cause: assert property (resp_valid_out && $past(clk_en_in)
      |-> $past(req)) else $error("Answer without a request.");
   chk_ptr_ack: assert property (ptr_go && byte_in < 8'h08 |=> ack_out)
      else $error("Mapped pointer not acknowledged.");
   chk_ptr_nack: assert property (ptr_go && byte_in >= 8'h08
      |=> !ack_out) else $error("Unused pointer acknowledged.");
   chk_ro_write: assert property ((ptr_go && byte_in < 8'h04)
      ##1 idle ##1 wr_go |=> !ack_out)
      else $error("Result write acknowledged.");
   chk_result_pad: assert property ((ptr_go && byte_in < 8'h04
      && !byte_in[0]) ##1 idle ##1 rd_go |=> rd_data_out[1:0] == 2'h0)
      else $error("Result pad bits not zero.");
   chk_reserved_low: assert property ((ptr_go && byte_in[1:0] != 2'h1
      && (byte_in == 8'h04 || byte_in == 8'h07)) ##1 idle ##1 rd_go
      |=> rd_data_out[2:0] == 3'h0) else $error("Reserved bits not zero.");
   chk_rdata_hold: assert property (!(clk_en_in && data_rd_in) &&
      !soft_reset_in |=> $stable(rd_data_out)) else $error("Read data moved.");
   chk_pin_idle: assert property ((clk_en_in && !pin_enable_in)[*2] ##0
      $stable(pin_polarity_in) |=> event_out_pin == !pin_polarity_in)
      else $error("Disabled pin not inactive.");
   // Main scenarios seen at the ports.
   cov_ptr_refused: cover property (ptr_go && byte_in >= 8'h08);
   cov_both_done: cover property (clk_en_in && temp_done_in && humid_done_in);
   cov_pin_active: cover property (pin_enable_in &&
      event_out_pin == pin_polarity_in);
endmodule // ensr_regs_top_monitor
bind ensr_regs_top ensr_regs_top_monitor mon (.sys_clk_in, .srst_in,
   .clk_en_in, .ptr_wr_in, .data_wr_in, .data_rd_in, .byte_in, .soft_reset_in,
   .pin_enable_in, .pin_polarity_in, .temp_done_in, .humid_done_in,
   .resp_valid_out, .ack_out, .rd_data_out, .event_out_pin);

// File: ensr_regs_top_bench.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the result and status registers.
// ****************************************************************
module ensr_regs_top_bench;
   logic sys_clk_in;
   logic srst_in = 1'b1, clk_en_in = 1'b1, soft_reset_in = 1'b0;
   logic temp_done_in = 1'b0, humid_done_in = 1'b0, auto_meas_in = 1'b0;
   logic pin_enable_in = 1'b0, pin_polarity_in = 1'b1, flag_mode_in = 1'b0;
   logic ptr_wr_in, data_wr_in, data_rd_in, resp_valid_out, ack_out;
   logic event_out_pin;
   logic [7:0] byte_in, rd_data_out;
   logic [13:0] temp_code_in = 14'h0000, humid_code_in = 14'h0000;
   logic [1:0] temp_res_in = 2'h0, humid_res_in = 2'h0;
   logic [7:0] temp_thr_low_in = 8'h00, temp_thr_high_in = 8'hFF;
   logic [7:0] humid_thr_low_in = 8'h00, humid_thr_high_in = 8'hFF;
   logic [15:0] exp_t = 16'h0000, exp_h = 16'h0000;
   logic [7:0] tpk = 8'h00, hpk = 8'h00;
   logic [4:0] fl = 5'h00;
   int n_errors = 0, cmp_count = 0;
   // Register block and host.
   ensr_regs_top DUT (.sys_clk_in, .srst_in, .clk_en_in, .ptr_wr_in,
      .data_wr_in, .data_rd_in, .byte_in, .resp_valid_out, .ack_out,
      .rd_data_out, .temp_done_in, .temp_code_in, .humid_done_in,
      .humid_code_in, .temp_res_in, .humid_res_in, .temp_thr_low_in,
      .temp_thr_high_in, .humid_thr_low_in, .humid_thr_high_in,
      .soft_reset_in, .auto_meas_in, .pin_enable_in, .pin_polarity_in,
      .flag_mode_in, .event_out_pin);
   ensr_host_model host (.sys_clk_in, .resp_valid_in(resp_valid_out),
      .ack_in(ack_out), .rd_data_in(rd_data_out), .ptr_wr_out(ptr_wr_in),
      .data_wr_out(data_wr_in), .data_rd_out(data_rd_in),
      .byte_out(byte_in));
   // Clock of 8 ns.
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   // Expected 16-bit result of a code at a resolution select.
   function automatic logic [15:0] res16(logic [13:0] c, logic [1:0] r);
      logic [13:0] m;
      m = (r == ensr_pkg::RES_11_BIT) ? ensr_pkg::MASK_11_BIT :
         (r == ensr_pkg::RES_9_BIT) ? ensr_pkg::MASK_9_BIT :
         ensr_pkg::MASK_14_BIT;
      return {c & m, 2'h0};
   endfunction
   // Compares a seen value with the expected one.
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Pointer load, data write and data read with answer checks.
   task automatic set_ptr(input logic [7:0] b, input logic a);
      host.xfer(2'h0, b);
      check({host.got_resp, host.got_ack, 8'h00}, {1'b1, a, 8'h00});
   endtask
   task automatic put(input logic [7:0] b, input logic a);
      host.xfer(2'h1, b);
      check({host.got_resp, host.got_ack, 8'h00}, {1'b1, a, 8'h00});
   endtask
   task automatic get(input logic a, input logic [7:0] e);
      host.xfer(2'h2, 8'h00);
      check({host.got_resp, host.got_ack, host.got_data},
         {1'b1, a, e});
   endtask
   // One conversion on both channels with fresh random settings.
   task automatic conv(input logic a);
      logic [4:0] hit;
      @(posedge sys_clk_in);
      temp_code_in <= 14'($urandom);
      humid_code_in <= 14'($urandom);
      {temp_res_in, humid_res_in} <= 4'($urandom);
      {temp_thr_low_in, temp_thr_high_in} <= 16'($urandom);
      {humid_thr_low_in, humid_thr_high_in} <= 16'($urandom);
      flag_mode_in <= 1'($urandom);
      auto_meas_in <= a;
      temp_done_in <= 1'b1;
      humid_done_in <= 1'b1;
      @(posedge sys_clk_in);
      temp_done_in <= 1'b0;
      humid_done_in <= 1'b0;
      exp_t = res16(temp_code_in, temp_res_in);
      exp_h = res16(humid_code_in, humid_res_in);
      hit = {1'b1, exp_t[15:8] > temp_thr_high_in,
         exp_t[15:8] < temp_thr_low_in,
         exp_h[15:8] > humid_thr_high_in, exp_h[15:8] < humid_thr_low_in};
      fl = flag_mode_in ? hit : (fl | hit);
      if (!a && exp_t[15:8] > tpk) tpk = exp_t[15:8];
      if (!a && exp_h[15:8] > hpk) hpk = exp_h[15:8];
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      #60us;
      n_errors++;
      tally_and_finish();
   end
   // Main sequence.
   initial begin
      void'($urandom(51));
      repeat (2) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      set_ptr(8'h00, 1'b1);
      for (int i = 0; i < 8; i++) begin
         get(1'b1, 8'h00);
      end
      get(1'b0, 8'h00);
      set_ptr(8'($urandom_range(8, 255)), 1'b0);
      get(1'b0, 8'h00);
      set_ptr(8'h00, 1'b1);
      put(8'hFF, 1'b0);
      set_ptr(8'h07, 1'b1);
      put(8'hFF, 1'b1);
      set_ptr(8'h07, 1'b1);
      get(1'b1, 8'hF8);
      set_ptr(8'h07, 1'b1);
      put(8'h80, 1'b1);
      for (int i = 0; i < 24; i++) begin
         conv(1'($urandom_range(0, 3) == 0));
         set_ptr(8'h00, 1'b1);
         get(1'b1, exp_t[7:0]);
         get(1'b1, exp_t[15:8]);
         get(1'b1, exp_h[7:0]);
         get(1'b1, exp_h[15:8]);
         get(1'b1, {1'b0, fl[3:0], 3'h0});
         fl = 5'h00;
         get(1'b1, tpk);
         get(1'b1, hpk);
         // A read made while the enable is low is ignored.
         @(posedge sys_clk_in);
         clk_en_in <= 1'b0;
         host.xfer(2'h2, 8'h00);
         check({1'b0, host.got_resp, host.got_data}, {2'h0, hpk});
         @(posedge sys_clk_in);
         clk_en_in <= 1'b1;
      end
      @(posedge sys_clk_in);
      pin_enable_in <= 1'b1;
      conv(1'b0);
      repeat (2) @(posedge sys_clk_in);
      #1;
      check({9'h000, event_out_pin}, 10'h001);
      set_ptr(8'h04, 1'b1);
      get(1'b1, {fl, 3'h0});
      fl = 5'h00;
      @(posedge sys_clk_in);
      #1;
      check({9'h000, event_out_pin}, 10'h000);
      @(posedge sys_clk_in);
      soft_reset_in <= 1'b1;
      @(posedge sys_clk_in);
      soft_reset_in <= 1'b0;
      set_ptr(8'h05, 1'b1);
      get(1'b1, 8'h00);
      get(1'b1, 8'h00);
      get(1'b1, 8'h00);
      // Host writes of the status, temperature peak and enable registers.
      set_ptr(8'h04, 1'b1);
      put(8'hF8, 1'b1);
      put(8'h5A, 1'b1);
      set_ptr(8'h04, 1'b1);
      get(1'b1, 8'hF8);
      get(1'b1, 8'h5A);
      get(1'b1, 8'h00);
      put(8'h80, 1'b1);
      // Active-low pin: idle high, low once data is ready.
      @(posedge sys_clk_in);
      pin_polarity_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      check({9'h000, event_out_pin}, 10'h001);
      conv(1'b0);
      repeat (2) @(posedge sys_clk_in);
      #1;
      check({9'h000, event_out_pin}, 10'h000);
      tally_and_finish();
   end
endmodule // ensr_regs_top_bench
